/* inc/wdt_regs.vh */
// Register offsets, field positions, reset values and timing counts
// for the watchdog and reset-source block. Definitions only.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// Byte offsets on the plain register port
`define WDT_CTRL_OFS 8'h00
`define WDT_RELOAD_OFS 8'h04
`define WDT_COUNT_OFS 8'h08
`define WDT_CMD_OFS 8'h0C

// Control register fields
`define CTRL_PRESCALE_BIT 0
`define CTRL_WDT_FLAG_BIT 1
`define CTRL_SW_FLAG_BIT 2
`define CTRL_SHORT_FLAG_BIT 3
`define CTRL_LONG_FLAG_BIT 4
`define CTRL_PON_FLAG_BIT 5
`define CTRL_BIDIR_BIT 6
`define CTRL_ENABLE_BIT 7
`define CTRL_INIT_DONE_BIT 8

// Command register fields (write-only pulses)
`define CMD_SERVICE_BIT 0
`define CMD_DISABLE_BIT 1
`define CMD_END_OF_INIT_INSTR_BIT 2
`define CMD_SWRST_BIT 3

// Reset values
`define RELOAD_RST 8'h00
`define COUNT_RST 16'h0000

// Timing: clock period and pin accept time in ns, hold and long times in half clock periods
`define CLK_PERIOD_NS 10
`define CLK_HALF_NS 5
`define RESET_IN_PIN_ACCEPT_NS 500
`define HOLD_TCL 12
`define LONG_TCL 1044
// Least times round up to whole cycles
`define RESET_IN_PIN_FILT_CYC ((`RESET_IN_PIN_ACCEPT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC ((`HOLD_TCL * `CLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_CYC ((`LONG_TCL * `CLK_HALF_NS + `RESET_IN_PIN_ACCEPT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* hdl/reset_in_pin_filter.v */
// Synchroniser and digital spike filter for the active-low reset input pin.
// Assumes the pin is asynchronous to clk; output level is glitch-free.
`default_nettype none
`include "wdt_regs.vh"

module reset_in_pin_filter (
	input wire clk,
	input wire rst,
	input wire pin_n,
	output reg level_q
);

	reg sync1_q; // First stage, read only by second stage
	reg sync2_q; // Second stage, safe to use
	reg [7:0] stable_q; // Cycles the synced level has differed from output

	// Two-flop synchroniser
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= pin_n;
			sync2_q <= sync1_q;
		end
	end

	// Level changes only after it has held for the accept time
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stable_q <= 8'h00;
			level_q <= 1'b1;
		end else if (sync2_q == level_q) begin
			stable_q <= 8'h00; // Spike ended early: discard it
		end else if (stable_q == (`RESET_IN_PIN_FILT_CYC - 1)) begin
			stable_q <= 8'h00;
			level_q <= sync2_q;
		end else begin
			stable_q <= stable_q + 8'h01;
		end
	end

endmodule
`default_nettype wire

/* hdl/wdt_reset_ctrl.v */
// Watchdog counter with prescaler, reload and reset-source classification.
// Assumes a plain register port on clk; reset pins come from the board.
// Functional notes
// - Watchdog enabled after reset; disable only pre-init
// - Overflow causes internal reset, reset_out low
// - 16-bit counter, clock divided by 2/128
// - Service loads reload value into high byte
// - Period equals (256-reload)*256*prescale cycles
// - Reset source kept as separate flags
// - End-of-init clears all reset-source flags
// - Software reset instruction resets, sets flag
// - Mode high, very long pulse: long flag
// - Mode high, shorter accepted pulse: short flag
// - Filter rejects spikes, accepts long pulses
// - Mode pin gates bidirectional drive on SW/WDT
// - Mode low, pin low: immediate reset
// - Mode high, pin low: synchronous reset
// - Bidirectional enable cleared by every reset
`default_nettype none
`include "wdt_regs.vh"

module wdt_reset_ctrl (
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire reset_in_pin_n,
	output reg reset_in_out,
	output reg reset_in_oe_n,
	input wire reset_mode_pin,
	output reg reset_out_pin_n,
	output reg sys_rst_q
);

	// One-hot states
	localparam [2:0] ST_RUN = 3'b001; // Normal operation
	localparam [2:0] ST_HWLOW = 3'b010; // Synchronous pin reset in progress
	localparam [2:0] ST_HOLD = 3'b100; // Internal reset stretch

	// Source codes for a starting reset
	localparam [1:0] SRC_WDT = 2'd0;
	localparam [1:0] SRC_SW = 2'd1;
	localparam [1:0] SRC_ASYNC = 2'd2;
	localparam [3:0] HOLD_INIT = `HOLD_CYC; // Reset stretch, sized to the hold counter

	reg [2:0] state_q; // Sequencer state
	reg [15:0] count_q; // Watchdog counter
	reg [6:0] pre_q; // Prescaler
	reg [7:0] reload_q; // Reload value
	reg prescale_q; // 0 = divide by 2, 1 = divide by 128
	reg enable_q; // Watchdog running
	reg init_done_q; // End-of-init executed
	reg bidir_q; // Bidirectional reset enable
	reg wdt_flag_q; // Last reset was watchdog
	reg sw_flag_q; // Last reset was software
	reg short_flag_q; // Last reset was short pin reset
	reg long_flag_q; // Last reset was long pin reset
	reg pon_flag_q; // Last reset was power-on or asynchronous
	reg [10:0] low_cnt_q; // Length of synchronous pin low
	reg [3:0] hold_q; // Hold counter
	reg drive_q; // Driving the reset input pin
	reg mode1_q; // Mode pin synchroniser, first stage
	reg mode2_q; // Mode pin synchroniser, second stage
	wire pin_level; // Filtered reset pin, low active

	// Prescaler tick and overflow
	wire tick; // Counting enable pulse
	wire overflow; // Counter wraps on this tick
	wire wr_cmd; // Command register write
	wire svc; // Service strobe
	wire end_of_init_instr; // End-of-init strobe
	wire swrst; // Software reset strobe

	// Address match, used for both read and write decode
	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	reset_in_pin_filter u_filter (
		.clk(clk),
		.rst(rst),
		.pin_n(reset_in_pin_n),
		.level_q(pin_level)
	);

	// Mode pin comes from the board: two flops before use
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mode1_q <= 1'b0;
			mode2_q <= 1'b0;
		end else begin
			mode1_q <= reset_mode_pin;
			mode2_q <= mode1_q;
		end
	end

	assign tick = enable_q && (state_q == ST_RUN) &&
		(prescale_q ? (pre_q == 7'h7F) : pre_q[0]);
	assign overflow = tick && (count_q == 16'hFFFF);
	assign wr_cmd = wr && hit(addr, `WDT_CMD_OFS);
	assign svc = wr_cmd && wdata[`CMD_SERVICE_BIT];
	assign end_of_init_instr = wr_cmd && wdata[`CMD_END_OF_INIT_INSTR_BIT];
	assign swrst = wr_cmd && wdata[`CMD_SWRST_BIT];

	// Prescaler and watchdog counter
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_q <= 7'h00;
			count_q <= `COUNT_RST;
		end else if (state_q != ST_RUN) begin
			pre_q <= 7'h00; // Held cleared through any reset
			count_q <= `COUNT_RST;
		end else if (svc) begin
			pre_q <= 7'h00; // Restart so the period is exact
			count_q <= {reload_q, 8'h00};
		end else begin
			pre_q <= pre_q + 7'h01;
			if (tick) begin
				count_q <= count_q + 16'h0001;
			end
		end
	end

	// Software-written configuration
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reload_q <= `RELOAD_RST;
			prescale_q <= 1'b0;
			bidir_q <= 1'b0;
			enable_q <= 1'b1;
			init_done_q <= 1'b0;
		end else if (state_q != ST_RUN) begin
			// Reset sequence restores defaults but keeps reload
			prescale_q <= 1'b0;
			bidir_q <= 1'b0;
			enable_q <= 1'b1;
			init_done_q <= 1'b0;
		end else begin
			if (wr && hit(addr, `WDT_RELOAD_OFS)) begin
				reload_q <= wdata[7:0];
			end
			if (wr && hit(addr, `WDT_CTRL_OFS)) begin
				prescale_q <= wdata[`CTRL_PRESCALE_BIT];
				bidir_q <= wdata[`CTRL_BIDIR_BIT];
			end
			// Disable allowed only before end of init
			if (wr_cmd && wdata[`CMD_DISABLE_BIT] && !init_done_q) begin
				enable_q <= 1'b0;
			end
			if (end_of_init_instr) begin
				init_done_q <= 1'b1;
			end
		end
	end

	// Reset sequencer and source flags
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_HOLD;
			hold_q <= HOLD_INIT;
			low_cnt_q <= 11'h000;
			drive_q <= 1'b0;
			wdt_flag_q <= 1'b0;
			sw_flag_q <= 1'b0;
			short_flag_q <= 1'b0;
			long_flag_q <= 1'b0;
			pon_flag_q <= 1'b1;
		end else begin
			case (state_q)
				ST_RUN: begin
					// Flags clear at end of init; a reset below wins
					if (end_of_init_instr) begin
						wdt_flag_q <= 1'b0;
						sw_flag_q <= 1'b0;
						short_flag_q <= 1'b0;
						long_flag_q <= 1'b0;
						pon_flag_q <= 1'b0;
					end
					if (!pin_level && !mode2_q) begin
						// Asynchronous pin reset, straight after filter
						start_reset(SRC_ASYNC);
					end else if (!pin_level) begin
						// Synchronous: filter already gave the 4 CLOCK_HALF_PERIOD minimum
						state_q <= ST_HWLOW;
						low_cnt_q <= 11'h000;
					end else if (overflow) begin
						start_reset(SRC_WDT);
					end else if (swrst) begin
						start_reset(SRC_SW);
					end
				end
				ST_HWLOW: begin
					if (!mode2_q) begin
						start_reset(SRC_ASYNC);
					end else if (pin_level) begin
						// Filter delays both edges alike, so the low run is the pulse length
						wdt_flag_q <= 1'b0;
						sw_flag_q <= 1'b0;
						pon_flag_q <= 1'b0;
						if (low_cnt_q >= `LONG_CYC) begin
							long_flag_q <= 1'b1;
							short_flag_q <= 1'b0;
						end else begin
							short_flag_q <= 1'b1;
							long_flag_q <= 1'b0;
						end
						state_q <= ST_HOLD;
						hold_q <= HOLD_INIT;
					end else if (low_cnt_q != 11'h7FF) begin
						low_cnt_q <= low_cnt_q + 11'h001;
					end
				end
				ST_HOLD: begin
					// Stretch, then wait for the pin to read high again
					if (hold_q != 4'h0) begin
						hold_q <= hold_q - 4'h1;
					end else if (drive_q) begin
						drive_q <= 1'b0; // Release our own pull first
					end else if (pin_level) begin
						state_q <= ST_RUN;
					end
				end
				default: begin
					state_q <= ST_HOLD;
					hold_q <= HOLD_INIT;
				end
			endcase
		end
	end

	// Begin a reset of the given source
	task start_reset;
		input [1:0] src;
		begin
			state_q <= ST_HOLD;
			hold_q <= HOLD_INIT;
			wdt_flag_q <= (src == SRC_WDT);
			sw_flag_q <= (src == SRC_SW);
			pon_flag_q <= (src == SRC_ASYNC);
			short_flag_q <= 1'b0;
			long_flag_q <= 1'b0;
			// Mode pin matters only with bidirectional reset enabled
			drive_q <= (src != SRC_ASYNC) && bidir_q && mode2_q;
		end
	endtask

	// Reset outputs, all registered
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_rst_q <= 1'b1;
			reset_out_pin_n <= 1'b0;
			reset_in_oe_n <= 1'b1;
			reset_in_out <= 1'b0;
		end else begin
			sys_rst_q <= (state_q != ST_RUN) || overflow || swrst;
			reset_out_pin_n <= (state_q == ST_RUN) && !overflow && !swrst;
			reset_in_oe_n <= !drive_q;
			reset_in_out <= 1'b0; // Pin is only ever pulled low
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= 32'h00000000;
			if (rd) begin
				if (hit(addr, `WDT_CTRL_OFS)) begin
					rdata[`CTRL_PRESCALE_BIT] <= prescale_q;
					rdata[`CTRL_WDT_FLAG_BIT] <= wdt_flag_q;
					rdata[`CTRL_SW_FLAG_BIT] <= sw_flag_q;
					rdata[`CTRL_SHORT_FLAG_BIT] <= short_flag_q;
					rdata[`CTRL_LONG_FLAG_BIT] <= long_flag_q;
					rdata[`CTRL_PON_FLAG_BIT] <= pon_flag_q;
					rdata[`CTRL_BIDIR_BIT] <= bidir_q;
					rdata[`CTRL_ENABLE_BIT] <= enable_q;
					rdata[`CTRL_INIT_DONE_BIT] <= init_done_q;
				end else if (hit(addr, `WDT_RELOAD_OFS)) begin
					rdata[7:0] <= reload_q;
				end else if (hit(addr, `WDT_COUNT_OFS)) begin
					rdata[15:0] <= count_q;
				end
				// Unmapped and command offsets read as zero
			end
		end
	end

endmodule
`default_nettype wire

/* testbench/wdt_assertions.sv */
// Checker for the watchdog and reset-source block ports.
// Assumes one clock domain and the async active-high reset.
`default_nettype none
module wdt_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic reset_in_pin_n,
	input wire logic reset_in_out,
	input wire logic reset_in_oe_n,
	input wire logic reset_out_pin_n,
	input wire logic sys_rst_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] low_q; // Raw pin low run, saturating
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Raw low run; 60 leaves room for sync and filter delay
	always @(posedge clk or posedge rst) begin
		if (rst)
			low_q <= 6'h00;
		else if (reset_in_pin_n)
			low_q <= 6'h00;
		else if (low_q != 6'h3F)
			low_q <= low_q + 6'h01;
	end
	// Reset hold spans the fixed settle period
	sequence hold_s;
		sys_rst_q[*6];
	endsequence
	out_follow_a: assert property ($rose(sys_rst_q) |=> !reset_out_pin_n) else $error("reset out not low");
	hold_len_a: assert property ($rose(sys_rst_q) |-> hold_s) else $error("reset hold too short");
	oe_reset_a: assert property (!reset_in_oe_n |-> sys_rst_q) else $error("pin driven outside reset");
	pin_zero_a: assert property (!reset_in_oe_n |-> !reset_in_out) else $error("pin driven high");
	oe_out_a: assert property (reset_out_pin_n |-> reset_in_oe_n) else $error("pin driven while running");
	pin_reset_a: assert property (low_q == 6'd60 |-> sys_rst_q) else $error("pin low ignored");
	por_out_a: assert property ($fell(rst) |-> sys_rst_q && !reset_out_pin_n) else $error("no power-on hold");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("read data not idle");
endmodule
bind wdt_reset_ctrl wdt_checker u_chk (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
	.reset_in_pin_n(reset_in_pin_n), .reset_in_out(reset_in_out), .reset_in_oe_n(reset_in_oe_n),
	.reset_out_pin_n(reset_out_pin_n), .sys_rst_q(sys_rst_q));
`default_nettype wire

/* testbench/reset_board.sv */
// Board model of the reset input circuit, pulled up.
// Assumes the bench commands pulses through pulse().
`default_nettype none
module reset_board (
	input wire logic clk,
	input wire logic reset_in_out,
	input wire logic reset_in_oe_n,
	output wire logic reset_in_pin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pull_q = 1'b0; // Board switch pulling low
	// Wired level: pull-up unless a party drives low
	assign reset_in_pin_n = !(pull_q || (!reset_in_oe_n && !reset_in_out));
	// Low for n clocks; short n makes a spike
	task automatic pulse(input int n);
		@(posedge clk);
		pull_q <= 1'b1;
		repeat (n) @(posedge clk);
		pull_q <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the watchdog and reset-source block.
// Assumes the board model and the bound checker.
`default_nettype none
`include "wdt_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t: %h", $time, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mode = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, r;
	wire pin_n, pin_out, pin_oe_n, out_n, sys_rst;
	int fails = 0, n_compared = 0, cyc = 0, n, rst_cyc = 0, oe_cyc = 0, mark = 0;
	wdt_reset_ctrl u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.reset_in_pin_n(pin_n), .reset_in_out(pin_out), .reset_in_oe_n(pin_oe_n), .reset_mode_pin(mode),
		.reset_out_pin_n(out_n), .sys_rst_q(sys_rst));
	reset_board u_board (.clk(clk), .reset_in_out(pin_out), .reset_in_oe_n(pin_oe_n), .reset_in_pin_n(pin_n));
	always #5 clk = ~clk;
	// Cycle ceiling, and running counts of reset and pin-drive cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sys_rst)
			rst_cyc <= rst_cyc + 1;
		if (!pin_oe_n)
			oe_cyc <= oe_cyc + 1;
		if (cyc == 80000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("fails %0d n_compared %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 r = rdata;
	endtask
	// Prescale bit masked, although every reset clears it to 0
	task automatic ctrl_is(input logic [8:0] e);
		rd_reg(`WDT_CTRL_OFS);
		`CHK({r[8:1], 1'b0}, e)
	endtask
	// Bounded wait for a reset to start, then end
	task automatic wait_done();
		n = 0;
		while (!sys_rst && n < 50) begin
			@(posedge clk) #1;
			n++;
		end
		while (sys_rst && n < 2000) begin
			@(posedge clk) #1;
			n++;
		end
	endtask
	// Power-on: only the power-on flag after the first sequence
	task automatic test_power_on();
		wait_done();
		ctrl_is(9'h0A0);
	endtask
	// Shortest period for both prescalers, then the watchdog flag
	task automatic test_period();
		for (int i = 0; i < 2; i++) begin
			wr_reg(`WDT_CTRL_OFS, {31'h0, i[0]});
			wr_reg(`WDT_RELOAD_OFS, 32'hFF);
			wr_reg(`WDT_CMD_OFS, 32'h1);
			rd_reg(`WDT_COUNT_OFS);
			`CHK(r[15:8], 8'hFF)
			`CHK(r[7:0] < 3, 1'b1)
			n = 2;
			while (!sys_rst && n < 40000) begin
				@(posedge clk) #1;
				n++;
			end
			`CHK(n >= (i ? 32767 : 511) && n <= (i ? 32770 : 514), 1'b1)
			wait_done();
			ctrl_is(9'h082);
		end
	endtask
	// End of init clears the flags and locks the disable command
	task automatic test_init_lock();
		wr_reg(`WDT_CMD_OFS, 32'h4);
		ctrl_is(9'h180);
		wr_reg(`WDT_CMD_OFS, 32'h2);
		ctrl_is(9'h180);
	endtask
	// Software reset sets its flag and reopens the disable window
	task automatic test_sw_reset();
		wr_reg(`WDT_CMD_OFS, 32'h8);
		wait_done();
		ctrl_is(9'h084);
		wr_reg(`WDT_CMD_OFS, 32'h2);
		ctrl_is(9'h004);
		mark = rst_cyc;
		repeat (1100) @(posedge clk);
		`CHK(rst_cyc - mark, 0)
	endtask
	// Pin driven on a software reset only with mode high
	task automatic test_bidir();
		for (int m = 0; m < 2; m++) begin
			mode <= m[0];
			wr_reg(`WDT_CTRL_OFS, 32'h40);
			mark = oe_cyc;
			wr_reg(`WDT_CMD_OFS, 32'h8);
			wait_done();
			`CHK(oe_cyc != mark, m[0])
			ctrl_is(9'h084);
		end
	endtask
	// Spike shorter than the filter time starts no reset
	task automatic test_spike();
		mark = rst_cyc;
		u_board.pulse(30);
		repeat (80) @(posedge clk);
		`CHK(rst_cyc - mark, 0)
	endtask
	// Short, long, asynchronous, then short just under the long threshold
	task automatic test_pin_resets();
		for (int k = 0; k < 4; k++) begin
			mode <= (k != 2);
			repeat (4) @(posedge clk);
			u_board.pulse(k == 1 ? 700 : k == 3 ? 540 : 100);
			wait_done();
			ctrl_is(k == 1 ? 9'h090 : k == 2 ? 9'h0A0 : 9'h088);
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		test_power_on();
		test_period();
		test_init_lock();
		test_sw_reset();
		test_bidir();
		test_spike();
		test_pin_resets();
		give_verdict();
	end
endmodule
`default_nettype wire
